// File: dorf_cfg.svh
// Constants for the operand register formatting block
`ifndef DORF_CFG_SVH
`define DORF_CFG_SVH
`define DORF_SEL_X0 6'h00
`define DORF_SEL_X1 6'h01
`define DORF_SEL_Y0 6'h02
`define DORF_SEL_Y1 6'h03
`define DORF_SEL_A0 6'h04
`define DORF_SEL_B0 6'h05
`define DORF_SEL_A2 6'h06
`define DORF_SEL_B2 6'h07
`define DORF_SEL_A1 6'h08
`define DORF_SEL_B1 6'h09
`define DORF_SEL_A 6'h0a
`define DORF_SEL_B 6'h0b
`define DORF_SEL_SR 6'h0c
`define DORF_SEL_MR 6'h0d
`define DORF_SEL_CCR 6'h0e
`define DORF_SEL_OMR 6'h0f
`define DORF_SEL_SP 6'h28
`define DORF_SEL_SSH 6'h29
`define DORF_SEL_SSL 6'h2a
`define DORF_SEL_LA 6'h2b
`define DORF_SEL_LC 6'h2c
`define DORF_GRP_R 3'h2
`define DORF_GRP_N 3'h3
`define DORF_GRP_M 3'h4
`define DORF_OMR_MASK 8'hc7
`define DORF_SCALE_HI 3
`define DORF_SCALE_LO 2
`define DORF_SCALE_DOWN 2'h1
`define DORF_SCALE_UP 2'h2
`define DORF_LIM_POS 24'h7fffff
`define DORF_LIM_NEG 24'h800000
`define DORF_PC_ONE 16'h0001
`define DORF_PC_TWO 16'h0002
`define DORF_NUM_OPS 6'h3e
`define DORF_NUM_PAR_OPS 6'h1e
`define DORF_OPC_HI 5
`define DORF_OPC_LO 0
`define DORF_PAR_HI 23
`define DORF_PAR_LO 16
`define DORF_EA_HI 13
`define DORF_EA_LO 11
`define DORF_EA_ABS 3'h6
`define DORF_EA_IMM 3'h7
`endif

// File: dorf_pkg.sv
// Types for the operand register formatting block
`default_nettype none
package dorf_pkg;
    typedef logic [5:0] dorf_sel_t;
    typedef enum logic [1:0] {DORF_SZ_WORD = 2'h0, DORF_SZ_SHORT = 2'h1,
        DORF_SZ_BYTE = 2'h2} dorf_size_e;
    typedef struct packed {
        logic en;
        logic wr;
        dorf_sel_t sel;
        dorf_size_e size;
        logic sgn;
        logic [23:0] wdata;
    } dorf_move_s;
    typedef struct packed {
        logic [23:0] x0, x1, y0, y1, a0, a1, b0, b1;
        logic [7:0] a2, b2;
        logic [7:0][15:0] r, n, m;
        logic [7:0] mr, condition_code_byte, operating_mode_reg;
        logic [15:0] lc, la, stack_top_high, stack_top_low, pc;
        logic [5:0] sp;
    } dorf_regs_s;
    typedef struct packed {
        logic needsExt;
        logic parOk;
        logic illegal;
        logic [23:0] imm;
    } dorf_dec_s;
endpackage
`default_nettype wire

// File: dorf_bus_format.sv
// Formats one register as a 24-bit bus source word
`timescale 1ns/1ns
`default_nettype none
`include "dorf_cfg.svh"
module dorf_bus_format import dorf_pkg::*; (
    // Register state and selection
    input wire dorf_regs_s regs,
    input wire dorf_sel_t sel,
    // Formatted word
    output logic [23:0] word
);
    logic [55:0] acc;
    logic [55:0] scaled;
    logic [1:0] scale;
    always_comb begin
        acc = (sel == `DORF_SEL_B) ? {regs.b2, regs.b1, regs.b0} : {regs.a2, regs.a1, regs.a0};
        scale = regs.mr[`DORF_SCALE_HI:`DORF_SCALE_LO];
        if (scale == `DORF_SCALE_DOWN) begin
            scaled = {acc[55], acc[55:1]};
        end else if (scale == `DORF_SCALE_UP) begin
            scaled = {acc[54:0], 1'b0};
        end else begin
            scaled = acc;
        end
        word = '0;
        if (sel == `DORF_SEL_X0) word = regs.x0;
        else if (sel == `DORF_SEL_X1) word = regs.x1;
        else if (sel == `DORF_SEL_Y0) word = regs.y0;
        else if (sel == `DORF_SEL_Y1) word = regs.y1;
        else if (sel == `DORF_SEL_A0) word = regs.a0;
        else if (sel == `DORF_SEL_B0) word = regs.b0;
        else if (sel == `DORF_SEL_A1) word = regs.a1;
        else if (sel == `DORF_SEL_B1) word = regs.b1;
        else if (sel == `DORF_SEL_A2) word = {{16{regs.a2[7]}}, regs.a2};
        else if (sel == `DORF_SEL_B2) word = {{16{regs.b2[7]}}, regs.b2};
        else if (sel == `DORF_SEL_A || sel == `DORF_SEL_B) begin
            // Saturate rather than wrap when the scaled value leaves 48 bits
            if (scaled[55:47] != {9{scaled[55]}}) begin
                word = scaled[55] ? `DORF_LIM_NEG : `DORF_LIM_POS;
            end else begin
                word = scaled[47:24];
            end
        end
        else if (sel[5:3] == `DORF_GRP_R) word = {8'h00, regs.r[sel[2:0]]};
        else if (sel[5:3] == `DORF_GRP_N) word = {8'h00, regs.n[sel[2:0]]};
        else if (sel[5:3] == `DORF_GRP_M) word = {8'h00, regs.m[sel[2:0]]};
        else if (sel == `DORF_SEL_SR) word = {8'h00, regs.mr, regs.condition_code_byte};
        else if (sel == `DORF_SEL_MR) word = {16'h0000, regs.mr};
        else if (sel == `DORF_SEL_CCR) word = {16'h0000, regs.condition_code_byte};
        else if (sel == `DORF_SEL_OMR) word = {16'h0000, regs.operating_mode_reg};
        else if (sel == `DORF_SEL_SP) word = {18'h00000, regs.sp};
        else if (sel == `DORF_SEL_SSH) word = {8'h00, regs.stack_top_high};
        else if (sel == `DORF_SEL_SSL) word = {8'h00, regs.stack_top_low};
        else if (sel == `DORF_SEL_LA) word = {8'h00, regs.la};
        else if (sel == `DORF_SEL_LC) word = {8'h00, regs.lc};
    end
endmodule
`default_nettype wire

// File: dorf_insn_decode.sv
// Splits an instruction into operation word fields and extension word use
`timescale 1ns/1ns
`default_nettype none
`include "dorf_cfg.svh"
module dorf_insn_decode import dorf_pkg::*; (
    // Instruction words
    input wire logic [23:0] opWord,
    input wire logic [23:0] extWord,
    // Decoded fields
    output dorf_dec_s dec
);
    logic [5:0] opc;
    logic [2:0] ea;
    logic parUsed;
    always_comb begin
        opc = opWord[`DORF_OPC_HI:`DORF_OPC_LO];
        ea = opWord[`DORF_EA_HI:`DORF_EA_LO];
        parUsed = |opWord[`DORF_PAR_HI:`DORF_PAR_LO];
        // At most one extension word, so two words is the longest form
        dec.needsExt = parUsed && (ea == `DORF_EA_ABS || ea == `DORF_EA_IMM);
        // Only the low opcodes may share the word with bus moves
        dec.parOk = opc < `DORF_NUM_PAR_OPS;
        dec.illegal = (opc >= `DORF_NUM_OPS) || (parUsed && !dec.parOk);
        dec.imm = dec.needsExt ? extWord : 24'h000000;
    end
endmodule
`default_nettype wire

// File: dorf_regfile.sv
// Program-visible register file with bus packing and instruction step
`timescale 1ns/1ns
`default_nettype none
`include "dorf_cfg.svh"
// Notes on behaviour
// - Instruction is one 24-bit word plus at most one extension word
// - X bus move, Y bus move and ALU write happen in one instruction
// - Immediate or absolute value comes from the extension word
// - Sizes: byte 8, short 16, word 24, long 48, accumulator 56 bits
// - Eight 24-bit data registers; long word pairs two, bit 47 top
// - Extension read: bits 0-7 value, bits 8-23 its sign
// - Extension write keeps only the low eight bits
// - Accumulator is extension:high:low, 56 bits, bit 55 top
// - Address, offset, modifier registers 16 bits, read zero-extended
// - Address-unit write keeps the low 16 bits
// - Mode register undefined bits ignore writes and read zero
// - Status word is system byte over condition byte, each accessible
// - Loop count, loop end, stack halves: 16 bits, zero-extended
// - Stack pointer is 6 bits, accessible as a word
// - Program counter is only implicit, 16 bits
// - Stack entries: program counter with status, or loop end with count
// - Byte and short memory values zero- or sign-extended on the bus
// - Parallel moves only for 30 of 62 operations
// - Opcodes without bus moves use other formats
// - Accumulator source scaled and limited; destination sign-filled
module dorf_regfile import dorf_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Instruction words
    input wire logic insnValid,
    input wire logic [23:0] opWord,
    input wire logic [23:0] extWord,
    // Bus moves
    input wire dorf_move_s xMove,
    input wire dorf_move_s yMove,
    // Data ALU result
    input wire logic aluWrEn,
    input wire logic aluWrB,
    input wire logic [55:0] aluWrData,
    // Read data
    output logic [23:0] xRdData,
    output logic [23:0] yRdData,
    // Operands toward the data ALU
    output logic [55:0] accA,
    output logic [55:0] accB,
    output logic [47:0] longX,
    output logic [47:0] longY,
    // Stack entries and program counter
    output logic [31:0] pcSrEntry,
    output logic [31:0] laLcEntry,
    output logic [15:0] pc,
    // Decode results
    output dorf_dec_s decOut
);
    typedef struct packed {
        dorf_regs_s regs;
        logic [23:0] xRd;
        logic [23:0] yRd;
        dorf_dec_s dec;
    } dorf_state_s;

    dorf_state_s st_reg;
    dorf_state_s st_next;
    logic [23:0] xFmt;
    logic [23:0] yFmt;
    dorf_dec_s dec;
    dorf_move_s mv [2];
    logic [23:0] w;

    ////////////////////////////////////////////////////////////////////////
    dorf_bus_format xFormat (
        .regs(st_reg.regs),
        .sel(xMove.sel),
        .word(xFmt)
    );
    dorf_bus_format yFormat (
        .regs(st_reg.regs),
        .sel(yMove.sel),
        .word(yFmt)
    );
    dorf_insn_decode decoder (
        .opWord(opWord),
        .extWord(extWord),
        .dec(dec)
    );

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        // Y is applied first so X wins when both hit one register
        mv[0] = yMove;
        mv[1] = xMove;
    end

    always_comb begin
        st_next = st_reg;
        w = '0;
        // ALU result goes in first; a bus move to the same accumulator wins
        if (aluWrEn) begin
            if (aluWrB) begin
                {st_next.regs.b2, st_next.regs.b1, st_next.regs.b0} = aluWrData;
            end else begin
                {st_next.regs.a2, st_next.regs.a1, st_next.regs.a0} = aluWrData;
            end
        end
        for (int i = 0; i < 2; i++) begin
            if (mv[i].en && mv[i].wr) begin
                if (mv[i].size == DORF_SZ_BYTE) begin
                    w = {mv[i].sgn ? {16{mv[i].wdata[7]}} : 16'h0000, mv[i].wdata[7:0]};
                end else if (mv[i].size == DORF_SZ_SHORT) begin
                    w = {mv[i].sgn ? {8{mv[i].wdata[15]}} : 8'h00, mv[i].wdata[15:0]};
                end else begin
                    w = mv[i].wdata;
                end
                if (mv[i].sel == `DORF_SEL_X0) st_next.regs.x0 = w;
                else if (mv[i].sel == `DORF_SEL_X1) st_next.regs.x1 = w;
                else if (mv[i].sel == `DORF_SEL_Y0) st_next.regs.y0 = w;
                else if (mv[i].sel == `DORF_SEL_Y1) st_next.regs.y1 = w;
                else if (mv[i].sel == `DORF_SEL_A0) st_next.regs.a0 = w;
                else if (mv[i].sel == `DORF_SEL_B0) st_next.regs.b0 = w;
                else if (mv[i].sel == `DORF_SEL_A1) st_next.regs.a1 = w;
                else if (mv[i].sel == `DORF_SEL_B1) st_next.regs.b1 = w;
                else if (mv[i].sel == `DORF_SEL_A2) st_next.regs.a2 = w[7:0];
                else if (mv[i].sel == `DORF_SEL_B2) st_next.regs.b2 = w[7:0];
                else if (mv[i].sel == `DORF_SEL_A) begin
                    st_next.regs.a2 = {8{w[23]}};
                    st_next.regs.a1 = w;
                    st_next.regs.a0 = '0;
                end
                else if (mv[i].sel == `DORF_SEL_B) begin
                    st_next.regs.b2 = {8{w[23]}};
                    st_next.regs.b1 = w;
                    st_next.regs.b0 = '0;
                end
                else if (mv[i].sel[5:3] == `DORF_GRP_R) begin
                    st_next.regs.r[mv[i].sel[2:0]] = w[15:0];
                end
                else if (mv[i].sel[5:3] == `DORF_GRP_N) begin
                    st_next.regs.n[mv[i].sel[2:0]] = w[15:0];
                end
                else if (mv[i].sel[5:3] == `DORF_GRP_M) begin
                    st_next.regs.m[mv[i].sel[2:0]] = w[15:0];
                end
                else if (mv[i].sel == `DORF_SEL_SR) begin
                    st_next.regs.mr = w[15:8];
                    st_next.regs.condition_code_byte = w[7:0];
                end
                else if (mv[i].sel == `DORF_SEL_MR) st_next.regs.mr = w[7:0];
                else if (mv[i].sel == `DORF_SEL_CCR) st_next.regs.condition_code_byte = w[7:0];
                else if (mv[i].sel == `DORF_SEL_OMR) begin
                    st_next.regs.operating_mode_reg = w[7:0] & `DORF_OMR_MASK;
                end
                else if (mv[i].sel == `DORF_SEL_SP) st_next.regs.sp = w[5:0];
                else if (mv[i].sel == `DORF_SEL_SSH) st_next.regs.stack_top_high = w[15:0];
                else if (mv[i].sel == `DORF_SEL_SSL) st_next.regs.stack_top_low = w[15:0];
                else if (mv[i].sel == `DORF_SEL_LA) st_next.regs.la = w[15:0];
                else if (mv[i].sel == `DORF_SEL_LC) st_next.regs.lc = w[15:0];
            end
        end
        // Reads sample the register values from before this edge
        if (xMove.en && !xMove.wr) st_next.xRd = xFmt;
        if (yMove.en && !yMove.wr) st_next.yRd = yFmt;
        // No select code reaches the counter; it only steps per instruction
        if (insnValid) begin
            st_next.regs.pc = st_reg.regs.pc + (dec.needsExt ? `DORF_PC_TWO : `DORF_PC_ONE);
            st_next.dec = dec;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign xRdData = st_reg.xRd;
    assign yRdData = st_reg.yRd;
    assign accA = {st_reg.regs.a2, st_reg.regs.a1, st_reg.regs.a0};
    assign accB = {st_reg.regs.b2, st_reg.regs.b1, st_reg.regs.b0};
    assign longX = {st_reg.regs.x1, st_reg.regs.x0};
    assign longY = {st_reg.regs.y1, st_reg.regs.y0};
    assign pcSrEntry = {st_reg.regs.pc, st_reg.regs.mr, st_reg.regs.condition_code_byte};
    assign laLcEntry = {st_reg.regs.la, st_reg.regs.lc};
    assign pc = st_reg.regs.pc;
    assign decOut = st_reg.dec;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    ext_read_a: assert property ((xMove.en && !xMove.wr && xMove.sel == `DORF_SEL_A2) |=>
        xRdData == {{16{$past(st_reg.regs.a2[7])}}, $past(st_reg.regs.a2)})
        else $error("extension read not sign-filled");
    ext_write_a: assert property ((xMove.en && xMove.wr && xMove.sel == `DORF_SEL_A2
        && xMove.size == DORF_SZ_WORD) |=> accA[55:48] == $past(xMove.wdata[7:0]))
        else $error("extension write wrong");
    agu_read_a: assert property ((xMove.en && !xMove.wr && xMove.sel[5:3] >= `DORF_GRP_R
        && xMove.sel[5:3] <= `DORF_GRP_M) |=> xRdData[23:16] == 8'h00)
        else $error("address unit read upper bits not zero");
    agu_write_a: assert property ((xMove.en && xMove.wr && xMove.sel[5:3] == `DORF_GRP_R
        && xMove.size == DORF_SZ_WORD)
        |=> st_reg.regs.r[$past(xMove.sel[2:0])] == $past(xMove.wdata[15:0]))
        else $error("address register write wrong");
    omr_res_a: assert property ((st_reg.regs.operating_mode_reg & ~`DORF_OMR_MASK) == 8'h00)
        else $error("mode register reserved bits set");
    acc_dest_a: assert property ((xMove.en && xMove.wr && xMove.sel == `DORF_SEL_A
        && xMove.size == DORF_SZ_WORD) |=> accA[23:0] == 24'h000000
        && accA[55:48] == {8{$past(xMove.wdata[23])}})
        else $error("accumulator destination not filled");
    pc_step_a: assert property (insnValid |=> pc == $past(pc)
        + ($past(dec.needsExt) ? `DORF_PC_TWO : `DORF_PC_ONE))
        else $error("program counter step wrong");
    pc_hold_a: assert property (!insnValid |=> $stable(pc))
        else $error("program counter moved without instruction");
    sp_read_a: assert property ((xMove.en && !xMove.wr && xMove.sel == `DORF_SEL_SP)
        |=> xRdData == {18'h00000, $past(st_reg.regs.sp)})
        else $error("stack pointer read wrong");
    byte_ext_a: assert property ((xMove.en && xMove.wr && xMove.sel == `DORF_SEL_X0
        && xMove.size == DORF_SZ_BYTE && xMove.sgn)
        |=> longX[23:8] == {16{$past(xMove.wdata[7])}})
        else $error("byte not sign-extended");
    par_ok_a: assert property ((insnValid && opWord[`DORF_OPC_HI:`DORF_OPC_LO] >=
        `DORF_NUM_PAR_OPS && |opWord[`DORF_PAR_HI:`DORF_PAR_LO]) |=> decOut.illegal)
        else $error("parallel move accepted for wrong opcode");

    // Control words: undefined bits must never leak onto the bus
    omr_write_a: assert property ((xMove.en && xMove.wr && xMove.sel == `DORF_SEL_OMR)
        |=> st_reg.regs.operating_mode_reg == ($past(xMove.wdata[7:0]) & `DORF_OMR_MASK))
        else $error("mode register write not masked");
    omr_read_a: assert property ((xMove.en && !xMove.wr && xMove.sel == `DORF_SEL_OMR)
        |=> xRdData == {16'h0000, $past(st_reg.regs.operating_mode_reg)})
        else $error("mode register read wrong");
    sp_write_a: assert property ((xMove.en && xMove.wr && xMove.sel == `DORF_SEL_SP)
        |=> st_reg.regs.sp == $past(xMove.wdata[5:0]))
        else $error("stack pointer write wrong");
    sr_write_a: assert property ((xMove.en && xMove.wr && xMove.sel == `DORF_SEL_SR
        && xMove.size == DORF_SZ_WORD) |=> pcSrEntry[15:0] == $past(xMove.wdata[15:0]))
        else $error("status word write wrong");
    sr_read_a: assert property ((xMove.en && !xMove.wr && xMove.sel == `DORF_SEL_SR)
        |=> xRdData == {8'h00, $past(pcSrEntry[15:0])})
        else $error("status word read wrong");
    mode_read_a: assert property ((xMove.en && !xMove.wr && xMove.sel == `DORF_SEL_MR)
        |=> xRdData == {16'h0000, $past(pcSrEntry[15:8])})
        else $error("system byte read wrong");
    cond_read_a: assert property ((xMove.en && !xMove.wr && xMove.sel == `DORF_SEL_CCR)
        |=> xRdData == {16'h0000, $past(pcSrEntry[7:0])})
        else $error("condition byte read wrong");
    ctl_read_a: assert property ((xMove.en && !xMove.wr && xMove.sel >= `DORF_SEL_SSH
        && xMove.sel <= `DORF_SEL_LC) |=> xRdData[23:16] == 8'h00)
        else $error("loop or stack half read not zero-extended");
    ctl_write_a: assert property ((xMove.en && xMove.wr && xMove.sel == `DORF_SEL_LC
        && xMove.size == DORF_SZ_WORD) |=> laLcEntry[15:0] == $past(xMove.wdata[15:0]))
        else $error("loop count write wrong");

    // Accumulator source path, unscaled
    acc_read_a: assert property ((xMove.en && !xMove.wr && xMove.sel == `DORF_SEL_A
        && st_reg.regs.mr[`DORF_SCALE_HI:`DORF_SCALE_LO] == 2'h0
        && st_reg.regs.a2 == {8{st_reg.regs.a1[23]}}) |=> xRdData == $past(st_reg.regs.a1))
        else $error("accumulator read not from high word");
    acc_sat_a: assert property ((xMove.en && !xMove.wr && xMove.sel == `DORF_SEL_A
        && st_reg.regs.mr[`DORF_SCALE_HI:`DORF_SCALE_LO] == 2'h0
        && st_reg.regs.a2 != {8{st_reg.regs.a1[23]}})
        |=> xRdData == ($past(st_reg.regs.a2[7]) ? `DORF_LIM_NEG : `DORF_LIM_POS))
        else $error("accumulator read not limited");
    // The ALU result into B must land whenever no bus move claims accumulator B
    alu_write_a: assert property ((aluWrEn && aluWrB
        && !(xMove.en && xMove.wr && xMove.sel inside {`DORF_SEL_B0, `DORF_SEL_B1,
        `DORF_SEL_B2, `DORF_SEL_B}) && !(yMove.en && yMove.wr && yMove.sel inside
        {`DORF_SEL_B0, `DORF_SEL_B1, `DORF_SEL_B2, `DORF_SEL_B}))
        |=> accB == $past(aluWrData))
        else $error("accumulator load from data unit lost");
    par_move_a: assert property ((xMove.en && xMove.wr && xMove.sel == `DORF_SEL_X0
        && xMove.size == DORF_SZ_WORD && yMove.en && yMove.wr && yMove.sel == `DORF_SEL_Y0
        && yMove.size == DORF_SZ_WORD) |=> longX[23:0] == $past(xMove.wdata)
        && longY[23:0] == $past(yMove.wdata))
        else $error("parallel bus moves did not land together");
    y_read_a: assert property ((yMove.en && !yMove.wr && yMove.sel == `DORF_SEL_Y0)
        |=> yRdData == $past(longY[23:0]))
        else $error("second bus read wrong");
    rd_hold_a: assert property (!(xMove.en && !xMove.wr) |=> $stable(xRdData))
        else $error("read data changed without a read");
    byte_zero_a: assert property ((xMove.en && xMove.wr && xMove.sel == `DORF_SEL_X0
        && xMove.size == DORF_SZ_BYTE && !xMove.sgn) |=> longX[23:8] == 16'h0000)
        else $error("byte not zero-extended");
    short_ext_a: assert property ((xMove.en && xMove.wr && xMove.sel == `DORF_SEL_X0
        && xMove.size == DORF_SZ_SHORT && xMove.sgn)
        |=> longX[23:0] == {{8{$past(xMove.wdata[15])}}, $past(xMove.wdata[15:0])})
        else $error("short word not sign-extended");

    // Decode results
    dec_hold_a: assert property (!insnValid |=> $stable(decOut))
        else $error("decode result moved without instruction");
    ext_take_a: assert property ((insnValid && dec.needsExt)
        |=> decOut.imm == $past(extWord))
        else $error("extension word not taken");
    no_ext_a: assert property ((insnValid && !dec.needsExt)
        |=> decOut.imm == 24'h000000 && !decOut.needsExt)
        else $error("extension word taken for one-word instruction");
    op_range_a: assert property ((insnValid && opWord[`DORF_OPC_HI:`DORF_OPC_LO] >=
        `DORF_NUM_OPS) |=> decOut.illegal)
        else $error("undefined operation accepted");
    par_legal_a: assert property ((insnValid && opWord[`DORF_OPC_HI:`DORF_OPC_LO] <
        `DORF_NUM_PAR_OPS) |=> !decOut.illegal && decOut.parOk)
        else $error("movable operation refused");
endmodule
`default_nettype wire

// File: dorf_regfile_test.sv
// Self-checking bench for the operand register formatting register file
`timescale 1ns/1ns
`default_nettype none
`include "dorf_cfg.svh"
module dorf_regfile_test import dorf_pkg::*;;
    logic clk = 1'b0;
    logic rstB = 1'b0;
    logic insnValid = 1'b0;
    logic [23:0] opWord = 24'h000000;
    logic [23:0] extWord = 24'h000000;
    dorf_move_s xMove = '0;
    dorf_move_s yMove = '0;
    logic aluWrEn = 1'b0;
    logic aluWrB = 1'b0;
    logic [55:0] aluWrData = 56'h0;
    logic [23:0] xRdData, yRdData;
    logic [55:0] accA, accB;
    logic [47:0] longX, longY;
    logic [31:0] pcSrEntry, laLcEntry;
    logic [15:0] pc;
    dorf_dec_s decOut;
    int miscompares = 0;
    int nTests = 0;

    always #20 clk = ~clk;

    dorf_regfile dut (
        .clk(clk), .rst_b(rstB), .insnValid(insnValid), .opWord(opWord), .extWord(extWord),
        .xMove(xMove), .yMove(yMove), .aluWrEn(aluWrEn), .aluWrB(aluWrB),
        .aluWrData(aluWrData), .xRdData(xRdData), .yRdData(yRdData), .accA(accA),
        .accB(accB), .longX(longX), .longY(longY), .pcSrEntry(pcSrEntry),
        .laLcEntry(laLcEntry), .pc(pc), .decOut(decOut)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [55:0] seen, input logic [55:0] exp);
        nTests++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Inputs change only at the falling edge, so every request is held across one rising edge
    task automatic xop(input logic w, input dorf_sel_t s, input dorf_size_e z, input logic g,
            input logic [23:0] d);
        xMove = '{en: 1'b1, wr: w, sel: s, size: z, sgn: g, wdata: d};
        @(negedge clk);
    endtask

    task automatic wr(input dorf_sel_t s, input logic [23:0] d);
        xop(1'b1, s, DORF_SZ_WORD, 1'b0, d);
    endtask

    // Read data is registered, so it is valid at the falling edge after the request edge
    task automatic rdChk(input string what, input dorf_sel_t s, input logic [23:0] exp);
        xop(1'b0, s, DORF_SZ_WORD, 1'b0, 24'h000000);
        check(what, {32'h0, xRdData}, {32'h0, exp});
    endtask

    task automatic insn(input logic [23:0] op, input logic [23:0] ext);
        insnValid = 1'b1;
        opWord = op;
        extWord = ext;
        @(negedge clk);
        insnValid = 1'b0;
        @(negedge clk);
    endtask

    task automatic conclude();
        if (miscompares == 0 && nTests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic dataRegs();
        wr(`DORF_SEL_X0, 24'h0a0b0c);
        wr(`DORF_SEL_X1, 24'h876543);
        check("longX", {8'h0, longX}, 56'h00_876543_0a0b0c);
        rdChk("x0", `DORF_SEL_X0, 24'h0a0b0c);
        xop(1'b1, `DORF_SEL_X0, DORF_SZ_BYTE, 1'b1, 24'h123480);
        rdChk("byteSigned", `DORF_SEL_X0, 24'hffff80);
        xop(1'b1, `DORF_SEL_X0, DORF_SZ_BYTE, 1'b0, 24'h123480);
        rdChk("byteZero", `DORF_SEL_X0, 24'h000080);
        xop(1'b1, `DORF_SEL_X0, DORF_SZ_SHORT, 1'b1, 24'h128000);
        rdChk("shortSigned", `DORF_SEL_X0, 24'hff8000);
    endtask

    task automatic controlRegs();
        dorf_sel_t ctl[4] = '{`DORF_SEL_LA, `DORF_SEL_LC, `DORF_SEL_SSH, `DORF_SEL_SSL};
        logic [2:0] grp[3] = '{`DORF_GRP_R, `DORF_GRP_N, `DORF_GRP_M};
        foreach (grp[i]) begin
            wr({grp[i], 3'h7}, 24'habcdef);
            rdChk("addrUnit", {grp[i], 3'h7}, 24'h00cdef);
        end
        foreach (ctl[i]) begin
            wr(ctl[i], 24'hfe0000 | 24'(i));
            rdChk("loopStack", ctl[i], 24'h000000 | 24'(i));
        end
        check("laLc", {24'h0, laLcEntry}, 56'h00000000000001);
        wr(`DORF_SEL_OMR, 24'hffffff);
        rdChk("omr", `DORF_SEL_OMR, 24'h0000c7);
        wr(`DORF_SEL_SP, 24'hffffff);
        rdChk("sp", `DORF_SEL_SP, 24'h00003f);
        wr(`DORF_SEL_SR, 24'hff1234);
        rdChk("sr", `DORF_SEL_SR, 24'h001234);
        rdChk("mr", `DORF_SEL_MR, 24'h000012);
        rdChk("ccr", `DORF_SEL_CCR, 24'h000034);
        check("pcSr", {40'h0, pcSrEntry[15:0]}, 56'h1234);
        wr(6'h30, 24'h00beef);
        rdChk("unmapped", 6'h30, 24'h000000);
    endtask

    task automatic accumulator();
        wr(`DORF_SEL_A, 24'h812345);
        check("accA", accA, 56'hff_812345_000000);
        rdChk("readA", `DORF_SEL_A, 24'h812345);
        wr(`DORF_SEL_A2, 24'h123401);
        check("accExt", {48'h0, accA[55:48]}, 56'h01);
        rdChk("limitPos", `DORF_SEL_A, 24'h7fffff);
        wr(`DORF_SEL_A2, 24'h123480);
        rdChk("extRead", `DORF_SEL_A2, 24'hffff80);
        rdChk("limitNeg", `DORF_SEL_A, 24'h800000);
        wr(`DORF_SEL_A, 24'h812345);
        wr(`DORF_SEL_MR, 24'h000004);
        rdChk("scaleDown", `DORF_SEL_A, 24'hc091a2);
        wr(`DORF_SEL_MR, 24'h000000);
    endtask

    // Three explicit transfers in one cycle must all land together
    task automatic parallelMoves();
        xMove = '{en: 1'b1, wr: 1'b1, sel: `DORF_SEL_X0, size: DORF_SZ_WORD, sgn: 1'b0,
            wdata: 24'h111111};
        yMove = '{en: 1'b1, wr: 1'b1, sel: `DORF_SEL_Y0, size: DORF_SZ_WORD, sgn: 1'b0,
            wdata: 24'h222222};
        aluWrEn = 1'b1;
        aluWrB = 1'b1;
        aluWrData = 56'h00_333333_444444;
        @(negedge clk);
        aluWrEn = 1'b0;
        xMove.en = 1'b0;
        yMove.wr = 1'b0;
        check("parX", {32'h0, longX[23:0]}, 56'h111111);
        check("parY", {32'h0, longY[23:0]}, 56'h222222);
        check("parAlu", accB, 56'h00_333333_444444);
        @(negedge clk);
        yMove.en = 1'b0;
        check("yRead", {32'h0, yRdData}, 56'h222222);
    endtask

    task automatic instructions();
        insn(24'h000005, 24'hffffff);
        check("pcOne", {40'h0, pc}, 56'h1);
        check("noExt", {55'h0, decOut.needsExt}, 56'h0);
        insn(24'h01301d, 24'ha5a5a5);
        check("pcTwo", {40'h0, pc}, 56'h3);
        check("absExt", {32'h0, decOut.imm}, 56'ha5a5a5);
        check("parLegal", {55'h0, decOut.illegal}, 56'h0);
        check("parOk", {55'h0, decOut.parOk}, 56'h1);
        insn(24'h01381c, 24'h5a5a5a);
        check("immExt", {32'h0, decOut.imm}, 56'h5a5a5a);
        check("pcImm", {40'h0, pc}, 56'h5);
        insn(24'h00383d, 24'h5a5a5a);
        check("lastOp", {55'h0, decOut.illegal}, 56'h0);
        check("plainNoExt", {32'h0, decOut.imm}, 56'h0);
        insn(24'h01001e, 24'h000000);
        check("parIllegal", {55'h0, decOut.illegal}, 56'h1);
        check("parRefused", {55'h0, decOut.parOk}, 56'h0);
        insn(24'h00003e, 24'h000000);
        check("opIllegal", {55'h0, decOut.illegal}, 56'h1);
        check("pcSrFull", {24'h0, pcSrEntry}, 56'h00080034);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(negedge clk);
        rstB = 1'b1;
        check("resetPc", {40'h0, pc}, 56'h0);
        check("resetAcc", accA, 56'h0);
        dataRegs();
        controlRegs();
        accumulator();
        parallelMoves();
        instructions();
        conclude();
    end

    // Guard against a stalled run
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        conclude();
    end
endmodule
`default_nettype wire
